//--- design/reg_field_defines.vh
`ifndef REG_FIELD_DEFINES_VH
`define REG_FIELD_DEFINES_VH

// field access behaviours
`define ACC_HW_INIT 3'h0
`define ACC_READ_CLEAR 3'h1
`define ACC_READ_CLEAR_WR 3'h2
`define ACC_READ_ONLY 3'h3
`define ACC_READ_WRITE 3'h4
`define ACC_W1C 3'h5
`define ACC_WR_UNLOCKED 3'h6

// reset classes
`define RCLASS_PLAIN 2'h0
`define RCLASS_STICKY 2'h1
`define RCLASS_SW_PERSIST 2'h2

// field indices (the access address)
`define FLD_HW_INIT 3'h0
`define FLD_READ_CLEAR 3'h1
`define FLD_READ_CLEAR_WR 3'h2
`define FLD_READ_ONLY 3'h3
`define FLD_READ_WRITE 3'h4
`define FLD_W1C 3'h5
`define FLD_WR_UNLOCKED 3'h6
`define FLD_SW_CTRL 3'h7

// bit position of the unlock bit inside the switch control field
`define UNLOCK_BIT 0

// initial values
`define INIT_ZERO 8'h00
`define INIT_RW 8'h00
`define INIT_WR_UNLOCKED 8'h00
`define INIT_SW_CTRL 8'h00

// access sources
`define SRC_EEPROM 2'h0
`define SRC_ROOT 2'h1
`define SRC_MGMT 2'h2

`endif

//--- design/access_arbiter.v
`include "reg_field_defines.vh"
`default_nettype none

// picks one of three access sources; the eeprom loader first, then root, then management
module access_arbiter (
  // requests, already gated by the caller
  input wire [2:0] req,
  // choice
  output reg take,
  output reg [1:0] src
);

  // fixed priority: the loader runs at start-up and must not be starved
  always @*
  begin
    take = 1'b1;
    src = `SRC_EEPROM;
    if (req[0])
      src = `SRC_EEPROM;
    else if (req[1])
      src = `SRC_ROOT;
    else if (req[2])
      src = `SRC_MGMT;
    else
      take = 1'b0;
  end

endmodule // access_arbiter

`default_nettype wire

//--- design/reg_field_cell.v
`include "reg_field_defines.vh"
`default_nettype none

// one 8-bit field whose access behaviour and reset class are parameters
module reg_field_cell #(
  parameter [2:0] ACCESS = `ACC_READ_WRITE,
  parameter [1:0] RCLASS = `RCLASS_PLAIN,
  parameter [7:0] INIT = `INIT_ZERO
) (
  // clock and resets
  input wire clk,
  input wire srst,
  input wire sw_fund_rst,
  input wire part_fund_rst,
  input wire other_rst,
  // access
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] wdata,
  input wire from_eeprom,
  input wire unlock,
  // hardware side
  input wire [7:0] strap_val,
  input wire [7:0] hw_set,
  input wire [7:0] hw_val,
  // value
  output reg [7:0] value_q
);

  reg [7:0] value_d;
  wire rst_hit;
  wire [7:0] init_val;

  ////////////////////////////////////////////////////////////////////////
  // reset selection
  assign rst_hit = srst | sw_fund_rst
                 | (part_fund_rst & (RCLASS != `RCLASS_SW_PERSIST))
                 | (other_rst & (RCLASS == `RCLASS_PLAIN));
  assign init_val = (ACCESS == `ACC_HW_INIT) ? strap_val : INIT;

  ////////////////////////////////////////////////////////////////////////
  // next value per access behaviour; hardware sets are or-ed last so a set wins
  always @*
  begin
    value_d = value_q;
    case (ACCESS)
      `ACC_HW_INIT:
        if (wr_en & from_eeprom)
          value_d = wdata;
      `ACC_READ_CLEAR:
        value_d = (rd_en ? 8'h00 : value_q) | hw_set;
      `ACC_READ_CLEAR_WR:
        value_d = (wr_en ? wdata : (rd_en ? 8'h00 : value_q)) | hw_set;
      `ACC_READ_ONLY:
        value_d = hw_val;
      `ACC_READ_WRITE:
        if (wr_en)
          value_d = wdata;
      `ACC_W1C:
        value_d = (value_q & ~(wr_en ? wdata : 8'h00)) | hw_set;
      `ACC_WR_UNLOCKED:
        if (wr_en & unlock)
          value_d = wdata;
      default:
        value_d = value_q;
    endcase
  end

  // reset is synchronous, so a strap value may be loaded here
  always @(posedge clk)
  begin
    if (rst_hit)
      value_q <= init_val;
    else
      value_q <= value_d;
  end

endmodule // reg_field_cell

`default_nettype wire

//--- design/reg_field_bank.v
`include "reg_field_defines.vh"
`default_nettype none

// Behaviour
// - all three sources obey identical field behaviour, except the strap-loaded field, which only the eeprom loader writes
// - strap-loaded field, eeprom-writable, then reset only
// - read-clear field returns value, then zeroes
// - writes to read-clear field ignored
// - read-clear-writable: read zeroes, write loads
// - read-only field follows hardware, ignores writes
// - read-write field reads last written value
// - one-to-clear: zero keeps, one clears
// - one-to-clear set only by hardware
// - unlocked field writable only when unlock set
// - unlocked field survives all but switch fundamental
// - sticky cleared by switch or partition fundamental
// - switch-persistent cleared by switch fundamental only
module reg_field_bank (
  // clock and reset
  input wire clk,
  input wire srst,
  // reset requests, one-cycle or level, active high
  input wire sw_fund_rst,
  input wire part_fund_rst,
  input wire other_rst,
  // root configuration access
  input wire root_req,
  input wire root_wr,
  input wire [2:0] root_addr,
  input wire [7:0] root_wdata,
  // management port access
  input wire mgmt_req,
  input wire mgmt_wr,
  input wire [2:0] mgmt_addr,
  input wire [7:0] mgmt_wdata,
  // eeprom loader access
  input wire eep_req,
  input wire eep_wr,
  input wire [2:0] eep_addr,
  input wire [7:0] eep_wdata,
  // hardware side
  input wire [7:0] strap_val,
  input wire [7:0] rc_hw_set,
  input wire [7:0] rcw_hw_set,
  input wire [7:0] w1c_hw_set,
  input wire [7:0] status_val,
  // answers
  output reg [2:0] ack_q,
  output reg rvalid_q,
  output reg [1:0] rsrc_q,
  output reg [7:0] rdata_q,
  // field values for the rest of the switch
  output wire [7:0] rw_value,
  output wire [7:0] ctrl_value,
  output wire [7:0] unlocked_value
);

  ////////////////////////////////////////////////////////////////////////
  // field table

  function [2:0] acc_of;
    input integer idx;
    begin
      case (idx)
        0: acc_of = `ACC_HW_INIT;
        1: acc_of = `ACC_READ_CLEAR;
        2: acc_of = `ACC_READ_CLEAR_WR;
        3: acc_of = `ACC_READ_ONLY;
        4: acc_of = `ACC_READ_WRITE;
        5: acc_of = `ACC_W1C;
        6: acc_of = `ACC_WR_UNLOCKED;
        default: acc_of = `ACC_READ_WRITE;
      endcase
    end
  endfunction

  // the lock field itself is forced switch-persistent; error flags are sticky
  function [1:0] class_of;
    input integer idx;
    begin
      case (idx)
        1: class_of = `RCLASS_STICKY;
        5: class_of = `RCLASS_STICKY;
        6: class_of = `RCLASS_SW_PERSIST;
        7: class_of = `RCLASS_SW_PERSIST;
        default: class_of = `RCLASS_PLAIN;
      endcase
    end
  endfunction

  function [7:0] init_of;
    input integer idx;
    begin
      case (idx)
        4: init_of = `INIT_RW;
        6: init_of = `INIT_WR_UNLOCKED;
        7: init_of = `INIT_SW_CTRL;
        default: init_of = `INIT_ZERO;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // source selection

  wire [2:0] req_vec;
  wire take;
  wire [1:0] src;
  reg sel_wr;
  reg [2:0] sel_addr;
  reg [7:0] sel_wdata;
  wire [63:0] field_bus;
  wire [63:0] hw_set_bus;
  wire unlock;

  // a source is not retaken in the cycle its acknowledge shows
  assign req_vec = {mgmt_req & ~ack_q[2], root_req & ~ack_q[1], eep_req & ~ack_q[0]};

  access_arbiter u_arb (
    .req(req_vec),
    .take(take),
    .src(src)
  );

  // one shared access path; only the strap-loaded field sees which source it is, and takes writes from the loader alone
  always @*
  begin
    sel_wr = eep_wr;
    sel_addr = eep_addr;
    sel_wdata = eep_wdata;
    case (src)
      `SRC_ROOT:
      begin
        sel_wr = root_wr;
        sel_addr = root_addr;
        sel_wdata = root_wdata;
      end
      `SRC_MGMT:
      begin
        sel_wr = mgmt_wr;
        sel_addr = mgmt_addr;
        sel_wdata = mgmt_wdata;
      end
      default:
      begin
        sel_wr = eep_wr;
        sel_addr = eep_addr;
        sel_wdata = eep_wdata;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // fields

  assign hw_set_bus = {8'h00, 8'h00, w1c_hw_set, 8'h00, 8'h00, rcw_hw_set, rc_hw_set, 8'h00};
  assign unlock = field_bus[`FLD_SW_CTRL * 8 + `UNLOCK_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_field
      // field index at the address width, so the compare keeps its size
      localparam [2:0] IDX = gi;
      wire hit;
      assign hit = take & (sel_addr == IDX);
      reg_field_cell #(
        .ACCESS(acc_of(gi)),
        .RCLASS(class_of(gi)),
        .INIT(init_of(gi))
      ) u_cell (
        .clk(clk),
        .srst(srst),
        .sw_fund_rst(sw_fund_rst),
        .part_fund_rst(part_fund_rst),
        .other_rst(other_rst),
        .wr_en(hit & sel_wr),
        .rd_en(hit & ~sel_wr),
        .wdata(sel_wdata),
        .from_eeprom(src == `SRC_EEPROM),
        .unlock(unlock),
        .strap_val(strap_val),
        .hw_set(hw_set_bus[gi * 8 +: 8]),
        .hw_val(status_val),
        .value_q(field_bus[gi * 8 +: 8])
      );
    end
  endgenerate

  assign rw_value = field_bus[`FLD_READ_WRITE * 8 +: 8];
  assign ctrl_value = field_bus[`FLD_SW_CTRL * 8 +: 8];
  assign unlocked_value = field_bus[`FLD_WR_UNLOCKED * 8 +: 8];

  ////////////////////////////////////////////////////////////////////////
  // answers: read data is the value before any read-clear takes effect

  always @(posedge clk)
  begin
    if (srst)
    begin
      ack_q <= 3'h0;
      rvalid_q <= 1'b0;
      rsrc_q <= `SRC_EEPROM;
      rdata_q <= 8'h00;
    end
    else
    begin
      ack_q <= 3'h0;
      rvalid_q <= 1'b0;
      if (take)
      begin
        ack_q[src] <= 1'b1;
        rsrc_q <= src;
        if (!sel_wr)
        begin
          rvalid_q <= 1'b1;
          rdata_q <= field_bus[sel_addr * 8 +: 8];
        end
      end
    end
  end

endmodule // reg_field_bank

`default_nettype wire

//--- sim/access_src.sv
`default_nettype none
// one requester on the bank: holds its request until the answer, then drives inverted junk on its bus lines
module access_src (
  // clock
  input wire logic clk,
  input wire logic srst,
  // command from the bench
  input wire logic go,
  input wire logic wr_c,
  input wire logic [2:0] addr_c,
  input wire logic [7:0] wdata_c,
  // bus side
  input wire logic ack,
  output logic req,
  output logic wr,
  output logic [2:0] addr,
  output logic [7:0] wdata,
  output logic busy_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // dropped inside the ack cycle; the bank also masks a request while its ack shows
  assign req = busy_q & ~ack;
  // whole fields only, so no reserved bits are left to merge
  always @(posedge clk)
    if (srst)
    begin
      busy_q <= 1'b0;
      {wr, addr, wdata} <= '0;
    end
    else if (busy_q && ack)
    begin
      busy_q <= 1'b0;
      {wr, addr, wdata} <= ~{wr, addr, wdata}; // released lines show junk
    end
    else if (go && !busy_q)
    begin
      busy_q <= 1'b1;
      {wr, addr, wdata} <= {wr_c, addr_c, wdata_c};
    end
endmodule // access_src
`default_nettype wire

//--- sim/reg_field_bank_properties.sv
`default_nettype none
// port-level checks of the field bank
module reg_field_bank_properties (
  // clock and resets
  input wire logic clk,
  input wire logic srst,
  input wire logic sw_fund_rst,
  input wire logic part_fund_rst,
  input wire logic other_rst,
  // requests
  input wire logic eep_req,
  input wire logic eep_wr,
  input wire logic [2:0] eep_addr,
  input wire logic [7:0] eep_wdata,
  input wire logic root_req,
  input wire logic mgmt_req,
  // answers and fields
  input wire logic [2:0] ack_q,
  input wire logic rvalid_q,
  input wire logic [7:0] rdata_q,
  input wire logic [7:0] rw_value,
  input wire logic [7:0] ctrl_value,
  input wire logic [7:0] unlocked_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // loader outranks everyone, so this is a take at this edge
  wire logic take = eep_req && !ack_q[0];
  wire logic quiet = !eep_req && !root_req && !mgmt_req && !sw_fund_rst;
  wire logic calm = !sw_fund_rst && !part_fund_rst && !other_rst;
  ////////////////////////////////////////
  property p_take; take |=> ack_q[0]; endproperty
  a_take: assert property (p_take) else $error("loader not answered");
  property p_once; ack_q[0] |=> !ack_q[0]; endproperty
  a_once: assert property (p_once) else $error("answer longer than one cycle");
  property p_prio; take && root_req |=> !ack_q[1]; endproperty
  a_prio: assert property (p_prio) else $error("root answered over loader");
  property p_rv; rvalid_q |-> ack_q != 3'h0; endproperty
  a_rv: assert property (p_rv) else $error("read data without answer");
  property p_rw; take && eep_wr && eep_addr == 3'h4 && calm |=> rw_value == $past(eep_wdata);
  endproperty
  a_rw: assert property (p_rw) else $error("write not loaded");
  property p_lock; take && eep_wr && eep_addr == 3'h6 && !ctrl_value[0] && calm
    |=> $stable(unlocked_value); endproperty
  a_lock: assert property (p_lock) else $error("locked field written");
  property p_keep; (part_fund_rst || other_rst) && quiet
    |=> $stable(unlocked_value) && $stable(ctrl_value); endproperty
  a_keep: assert property (p_keep) else $error("persistent field lost");
  property p_plain; part_fund_rst || other_rst |=> rw_value == 8'h00; endproperty
  a_plain: assert property (p_plain) else $error("plain field kept");
  property p_swrst; sw_fund_rst |=> (ctrl_value | unlocked_value | rw_value) == 8'h00;
  endproperty
  a_swrst: assert property (p_swrst) else $error("field survived switch reset");
  property p_hold; !rvalid_q && !$past(srst) |-> $stable(rdata_q); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // main scenarios
  c_unlk: cover property (take && eep_wr && eep_addr == 3'h6 && ctrl_value[0]);
  c_both: cover property (eep_req && mgmt_req);
  c_keep: cover property (part_fund_rst && unlocked_value != 8'h00);
endmodule // reg_field_bank_properties
bind reg_field_bank reg_field_bank_properties props (.clk, .srst, .sw_fund_rst,
  .part_fund_rst, .other_rst, .eep_req, .eep_wr, .eep_addr, .eep_wdata, .root_req,
  .mgmt_req, .ack_q, .rvalid_q, .rdata_q, .rw_value, .ctrl_value, .unlocked_value);
`default_nettype wire

//--- sim/reg_field_bank_test.sv
`default_nettype none
module reg_field_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, sw_fund_rst, part_fund_rst, other_rst, wr_c, rvalid_q;
  logic [2:0] go, req, wr, ack_q, busy, addr_c;
  logic [2:0] addr [3];
  logic [7:0] wdata [3];
  logic [7:0] wdata_c, strap_val, rc_hw_set, rcw_hw_set, w1c_hw_set, status_val, v, m;
  logic [7:0] rdata_q, rw_value, ctrl_value, unlocked_value;
  logic [1:0] rsrc_q;
  logic [9:0] exp_q [$];
  int errors = 0;
  int checks_done = 0;
  // index 0 loader, 1 root, 2 management
  for (genvar i = 0; i < 3; i++)
  begin : g_src
    access_src src (.clk, .srst, .go(go[i]), .wr_c, .addr_c, .wdata_c, .ack(ack_q[i]),
      .req(req[i]), .wr(wr[i]), .addr(addr[i]), .wdata(wdata[i]), .busy_q(busy[i]));
  end
  reg_field_bank dut (.clk, .srst, .sw_fund_rst, .part_fund_rst, .other_rst,
    .root_req(req[1]), .root_wr(wr[1]), .root_addr(addr[1]), .root_wdata(wdata[1]),
    .mgmt_req(req[2]), .mgmt_wr(wr[2]), .mgmt_addr(addr[2]), .mgmt_wdata(wdata[2]),
    .eep_req(req[0]), .eep_wr(wr[0]), .eep_addr(addr[0]), .eep_wdata(wdata[0]),
    .strap_val, .rc_hw_set, .rcw_hw_set, .w1c_hw_set, .status_val, .ack_q, .rvalid_q,
    .rsrc_q, .rdata_q, .rw_value, .ctrl_value, .unlocked_value);
  ////////////////////////////////////////
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one access from source s, waited out under a bound
  task automatic acc(input int s, input logic w, input logic [2:0] a, input logic [7:0] d);
    int n;
    {wr_c, addr_c, wdata_c} = {w, a, d};
    go[s] = 1'b1;
    @(posedge clk) #1 go = 3'h0;
    for (n = 0; busy !== 3'h0 && n < 20; n++) @(posedge clk) #1;
    if (n == 20) check("answer", 10'h0, 10'h1);
  endtask
  task automatic rd(input int s, input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back({s[1:0], e});
    acc(s, 1'b0, a, 8'h00);
  endtask
  task automatic pulse(input int k);
    {sw_fund_rst, part_fund_rst, other_rst} = 3'h4 >> k;
    @(posedge clk) #1 {sw_fund_rst, part_fund_rst, other_rst} = 3'h0;
  endtask
  task automatic hw(input logic [7:0] x);
    {rc_hw_set, rcw_hw_set, w1c_hw_set} = {x, ~x, x};
    @(posedge clk) #1 {rc_hw_set, rcw_hw_set, w1c_hw_set} = '0;
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // every bit of a field is defined, so nothing is masked before comparing
  always @(negedge clk)
    if (rvalid_q === 1'b1)
      check("read", {rsrc_q, rdata_q}, exp_q.size() ? exp_q.pop_front() : 10'hx);
  // hang guard, far beyond the fewer than two hundred cycles the sequence needs
  initial
  begin
    #200us;
    errors++;
    end_of_test();
  end
  initial
  begin
    {sw_fund_rst, part_fund_rst, other_rst, go, wr_c, addr_c, wdata_c} = '0;
    {rc_hw_set, rcw_hw_set, w1c_hw_set, m} = '0;
    v = $urandom(32'h108b);
    {strap_val, status_val} = {$urandom, $urandom};
    srst = 1'b1;
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    rd(1, 3'h0, strap_val);
    for (int s = 0; s < 3; s++)
    begin
      v = $urandom;
      acc(s, 1'b1, 3'h4, v);
      rd((s + 1) % 3, 3'h4, v);
      acc(s, 1'b1, 3'h3, ~status_val);
      rd(s, 3'h3, status_val);
      acc(s, 1'b1, 3'h1, v);
      rd(s, 3'h1, 8'h00);
      acc(s, 1'b1, 3'h0, ~strap_val);
      rd(s, 3'h0, ~strap_val);
    end
    hw(v);
    pulse(2);
    rd(1, 3'h0, strap_val);
    rd(2, 3'h1, v);
    rd(2, 3'h1, 8'h00);
    rd(0, 3'h2, 8'h00);
    acc(1, 1'b1, 3'h5, ~v);
    rd(1, 3'h5, v);
    m = $urandom;
    acc(2, 1'b1, 3'h5, m);
    rd(2, 3'h5, v & ~m);
    rd(0, 3'h5, v & ~m);
    pulse(1);
    rd(0, 3'h5, 8'h00);
    acc(2, 1'b1, 3'h2, m);
    rd(1, 3'h2, m);
    rd(0, 3'h2, 8'h00);
    status_val = ~status_val;
    rd(2, 3'h3, status_val);
    acc(0, 1'b1, 3'h6, v);
    rd(1, 3'h6, 8'h00);
    acc(1, 1'b1, 3'h7, 8'h01);
    acc(2, 1'b1, 3'h6, v);
    acc(0, 1'b1, 3'h4, m);
    pulse(1);
    pulse(2);
    rd(0, 3'h6, v);
    rd(1, 3'h7, 8'h01);
    rd(2, 3'h4, 8'h00);
    pulse(0);
    rd(0, 3'h6, 8'h00);
    rd(1, 3'h7, 8'h00);
    // loader and management at once: loader answered first, the other waits
    exp_q.push_back({2'h0, strap_val});
    go[0] = 1'b1;
    rd(2, 3'h0, strap_val);
    repeat (4) @(posedge clk);
    check("pending", 10'(exp_q.size()), 10'h0);
    end_of_test();
  end
endmodule // reg_field_bank_test
`default_nettype wire
